// File: inc/tic_consts.svh
// Constants of the time interval counter: addresses, bit positions, limits
`ifndef TIC_CONSTS_SVH
`define TIC_CONSTS_SVH

`define TIC_ADDR_CTRL 8'hA1
`define TIC_ADDR_FRAC 8'hA2
`define TIC_ADDR_SEC 8'hA3
`define TIC_ADDR_MIN 8'hA4
`define TIC_ADDR_HOUR 8'hA5
`define TIC_ADDR_CMP 8'hA6

`define TIC_BIT_TIME_CLOCK_ENABLE 0
`define TIC_BIT_INTERVAL_ENABLE 1
`define TIC_BIT_FLAG 2
`define TIC_BIT_ONESHOT 3
`define TIC_BIT_SEL_LO 4
`define TIC_BIT_SEL_HI 5
`define TIC_BIT_TFH 6

`define TIC_SEL_FRAC 2'h0
`define TIC_SEL_SEC 2'h1
`define TIC_SEL_MIN 2'h2
`define TIC_SEL_HOUR 2'h3

`define TIC_BYTE_ZERO 8'h00
`define TIC_BYTE_ONE 8'h01
`define TIC_FRAC_MAX 8'h7F
`define TIC_SEC_MAX 8'h3B
`define TIC_MIN_MAX 8'h3B
`define TIC_HOUR24_MAX 8'h17
`define TIC_HOUR255_MAX 8'hFF
`define TIC_PRESCALE_MAX 8'hFF

`endif

// File: inc/tic_pkg.sv
// Types shared by the time interval counter modules
`include "tic_consts.svh"
package tic_pkg;
    typedef logic [7:0] tic_byte_t;
    typedef enum logic [1:0] {
        TIC_BASE_FRAC = `TIC_SEL_FRAC,
        TIC_BASE_SEC = `TIC_SEL_SEC,
        TIC_BASE_MIN = `TIC_SEL_MIN,
        TIC_BASE_HOUR = `TIC_SEL_HOUR
    } tic_base_sel_t;
endpackage

// File: inc/tic_cnt_if.sv
// Signals between the control logic and one wrapping time counter
`timescale 1ns/1ps
interface tic_cnt_if;
    logic tick;
    logic clr;
    logic load;
    tic_pkg::tic_byte_t loadVal;
    tic_pkg::tic_byte_t maxVal;
    tic_pkg::tic_byte_t value;
    logic wrap;
    modport cnt (input tick, input clr, input load, input loadVal, input maxVal,
                 output value, output wrap);
    modport ctl (output tick, output clr, output load, output loadVal, output maxVal,
                 input value, input wrap);
endinterface

// File: rtl/tic_wrap_cnt.sv
// One wrapping time counter with clear, load and carry out
`timescale 1ns/1ps
`include "tic_consts.svh"
module tic_wrap_cnt (
    input wire logic mclk,
    input wire logic arst_n,
    tic_cnt_if.cnt c
);
    import tic_pkg::*;

    tic_byte_t value_ff;
    tic_byte_t nxt_value;
    wire atTop;

    // Values above the limit, e.g. loaded by software, also wrap on the next tick
    assign atTop = value_ff >= c.maxVal;
    assign nxt_value = c.clr ? `TIC_BYTE_ZERO :
                       c.load ? c.loadVal :
                       !c.tick ? value_ff :
                       atTop ? `TIC_BYTE_ZERO : value_ff + `TIC_BYTE_ONE;
    assign c.value = value_ff;
    assign c.wrap = c.tick & atTop & ~c.clr & ~c.load;

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            value_ff <= `TIC_BYTE_ZERO;
        else
            value_ff <= nxt_value;
    end
endmodule // tic_wrap_cnt

// File: rtl/tic_time_interval_regs.sv
// Time keeping counters and interval alarm with their special function registers
// Notes on behaviour
// - Interval counter reaching compare value sets the flag; interrupt if enabled.
// - Compare register is software writable with any value 0 to 255.
// - With clock enabled, fraction counter steps at 128 Hz, 0..127, carries to seconds.
// - Seconds count 0..59 then wrap and carry into minutes.
// - Minutes count 0..59 then wrap and carry into hours.
// - With 24-hour mode set, hours count 0..23 then wrap.
// - With 24-hour mode clear, hours count 0..255 then wrap.
// - Clearing clock enable stops ticks, clears time; time writable only while low.
// - Two-bit base select picks interval tick: fraction, seconds, minutes, hours.
// - One-shot timeout clears interval enable; otherwise counter reloads and restarts.
// - Software clears the flag; clearing interval enable stops and zeroes counter.
`timescale 1ns/1ps
`include "tic_consts.svh"
module tic_time_interval_regs (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic timeBasePin,
    input wire tic_pkg::tic_byte_t sfrAddr,
    input wire tic_pkg::tic_byte_t sfrWrData,
    input wire logic sfrWe,
    input wire logic sfrRe,
    output tic_pkg::tic_byte_t sfrRdData,
    input wire logic irqEnable,
    output logic intervalFlag,
    output logic intervalIrq
);
    import tic_pkg::*;

    logic tbSync1_ff;
    logic tbSync2_ff;
    logic tbPrev_ff;
    tic_byte_t prescale_ff;
    logic time_clock_enable_ff;
    logic interval_enable_ff;
    logic flag_ff;
    logic oneShot_ff;
    logic tfh_ff;
    tic_base_sel_t baseSel_ff;
    tic_byte_t cmp_ff;
    tic_byte_t intCnt_ff;
    tic_byte_t rdData_ff;
    tic_byte_t nxt_intCnt;
    logic nxt_interval_enable;
    logic nxt_flag;

    tic_cnt_if fracIf();
    tic_cnt_if secIf();
    tic_cnt_if minIf();
    tic_cnt_if hourIf();

    wire tbEdge;
    wire tick128;
    wire wrCtrl;
    wire wrCmp;
    wire tcenFall;
    wire timeWrOk;
    wire intTick;
    wire intMatch;
    tic_byte_t intInc;
    tic_byte_t ctrlRead;
    tic_byte_t rdMux;

    // Time base pin crosses into mclk before the edge detector sees it
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            tbSync1_ff <= 1'b0;
            tbSync2_ff <= 1'b0;
            tbPrev_ff <= 1'b0;
        end
        else
        begin
            tbSync1_ff <= timeBasePin;
            tbSync2_ff <= tbSync1_ff;
            tbPrev_ff <= tbSync2_ff;
        end
    end

    assign tbEdge = tbSync2_ff & ~tbPrev_ff;
    assign tick128 = tbEdge & time_clock_enable_ff & (prescale_ff == `TIC_PRESCALE_MAX);

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            prescale_ff <= `TIC_BYTE_ZERO;
        else if (!time_clock_enable_ff)
            prescale_ff <= `TIC_BYTE_ZERO;
        else if (tbEdge)
            prescale_ff <= prescale_ff + `TIC_BYTE_ONE;
    end

    // Register decode
    assign wrCtrl = sfrWe & (sfrAddr == `TIC_ADDR_CTRL);
    assign wrCmp = sfrWe & (sfrAddr == `TIC_ADDR_CMP);
    assign tcenFall = wrCtrl & time_clock_enable_ff & ~sfrWrData[`TIC_BIT_TIME_CLOCK_ENABLE];
    assign timeWrOk = sfrWe & ~time_clock_enable_ff;

    // Time cascade
    assign fracIf.tick = tick128;
    assign fracIf.clr = tcenFall;
    assign fracIf.load = timeWrOk & (sfrAddr == `TIC_ADDR_FRAC);
    assign fracIf.loadVal = sfrWrData;
    assign fracIf.maxVal = `TIC_FRAC_MAX;

    assign secIf.tick = fracIf.wrap;
    assign secIf.clr = tcenFall;
    assign secIf.load = timeWrOk & (sfrAddr == `TIC_ADDR_SEC);
    assign secIf.loadVal = sfrWrData;
    assign secIf.maxVal = `TIC_SEC_MAX;

    assign minIf.tick = secIf.wrap;
    assign minIf.clr = tcenFall;
    assign minIf.load = timeWrOk & (sfrAddr == `TIC_ADDR_MIN);
    assign minIf.loadVal = sfrWrData;
    assign minIf.maxVal = `TIC_MIN_MAX;

    assign hourIf.tick = minIf.wrap;
    assign hourIf.clr = tcenFall;
    assign hourIf.load = timeWrOk & (sfrAddr == `TIC_ADDR_HOUR);
    assign hourIf.loadVal = sfrWrData;
    assign hourIf.maxVal = tfh_ff ? `TIC_HOUR24_MAX : `TIC_HOUR255_MAX;

    tic_wrap_cnt fracCnt (.mclk(mclk), .arst_n(arst_n), .c(fracIf.cnt));
    tic_wrap_cnt secCnt (.mclk(mclk), .arst_n(arst_n), .c(secIf.cnt));
    tic_wrap_cnt minCnt (.mclk(mclk), .arst_n(arst_n), .c(minIf.cnt));
    tic_wrap_cnt hourCnt (.mclk(mclk), .arst_n(arst_n), .c(hourIf.cnt));

    // Interval counter
    assign intTick = (baseSel_ff == TIC_BASE_FRAC) ? tick128 :
                     (baseSel_ff == TIC_BASE_SEC) ? fracIf.wrap :
                     (baseSel_ff == TIC_BASE_MIN) ? secIf.wrap : minIf.wrap;
    assign intInc = intCnt_ff + `TIC_BYTE_ONE;
    assign intMatch = interval_enable_ff & intTick & (intInc == cmp_ff);
    assign nxt_intCnt = !interval_enable_ff ? `TIC_BYTE_ZERO :
                        intMatch ? `TIC_BYTE_ZERO :
                        intTick ? intInc : intCnt_ff;
    // A software write of the enable beats the one-shot clear in the same cycle
    assign nxt_interval_enable = wrCtrl ? sfrWrData[`TIC_BIT_INTERVAL_ENABLE] :
                      (intMatch & oneShot_ff) ? 1'b0 : interval_enable_ff;
    // A match in the cycle of a software clear keeps the flag set
    assign nxt_flag = intMatch | (wrCtrl ? sfrWrData[`TIC_BIT_FLAG] : flag_ff);

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            time_clock_enable_ff <= 1'b0;
            interval_enable_ff <= 1'b0;
            flag_ff <= 1'b0;
            oneShot_ff <= 1'b0;
            tfh_ff <= 1'b0;
            baseSel_ff <= TIC_BASE_FRAC;
            cmp_ff <= `TIC_BYTE_ZERO;
            intCnt_ff <= `TIC_BYTE_ZERO;
        end
        else
        begin
            interval_enable_ff <= nxt_interval_enable;
            flag_ff <= nxt_flag;
            intCnt_ff <= nxt_intCnt;
            if (wrCtrl)
            begin
                time_clock_enable_ff <= sfrWrData[`TIC_BIT_TIME_CLOCK_ENABLE];
                oneShot_ff <= sfrWrData[`TIC_BIT_ONESHOT];
                tfh_ff <= sfrWrData[`TIC_BIT_TFH];
                baseSel_ff <= tic_base_sel_t'(sfrWrData[`TIC_BIT_SEL_HI:`TIC_BIT_SEL_LO]);
            end
            if (wrCmp)
                cmp_ff <= sfrWrData;
        end
    end

    // Read path: data appear one cycle after the read strobe, unmapped reads zero
    assign ctrlRead = {1'b0, tfh_ff, baseSel_ff, oneShot_ff, flag_ff, interval_enable_ff, time_clock_enable_ff};
    assign rdMux = (sfrAddr == `TIC_ADDR_CTRL) ? ctrlRead :
                   (sfrAddr == `TIC_ADDR_FRAC) ? fracIf.value :
                   (sfrAddr == `TIC_ADDR_SEC) ? secIf.value :
                   (sfrAddr == `TIC_ADDR_MIN) ? minIf.value :
                   (sfrAddr == `TIC_ADDR_HOUR) ? hourIf.value :
                   (sfrAddr == `TIC_ADDR_CMP) ? cmp_ff : `TIC_BYTE_ZERO;

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            rdData_ff <= `TIC_BYTE_ZERO;
        else if (sfrRe)
            rdData_ff <= rdMux;
    end

    assign sfrRdData = rdData_ff;
    assign intervalFlag = flag_ff;
    assign intervalIrq = flag_ff & irqEnable;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);

    sequence fracWrapS;
        tick128 && fracIf.value >= `TIC_FRAC_MAX && !tcenFall;
    endsequence
    sequence oneShotHitS;
        intMatch && oneShot_ff && !wrCtrl;
    endsequence

    frac_wrap_a: assert property (fracWrapS |=> fracIf.value == `TIC_BYTE_ZERO)
        else $error("fraction counter did not wrap after 127");
    frac_step_a: assert property (tick128 && fracIf.value < `TIC_FRAC_MAX && !tcenFall
        |=> fracIf.value == $past(fracIf.value) + `TIC_BYTE_ONE)
        else $error("fraction counter did not step");
    sec_carry_a: assert property (fracWrapS ##0 secIf.value >= `TIC_SEC_MAX
        |=> secIf.value == `TIC_BYTE_ZERO && minIf.value != $past(minIf.value))
        else $error("seconds did not wrap into minutes");
    min_carry_a: assert property (minIf.wrap |=> minIf.value == `TIC_BYTE_ZERO)
        else $error("minutes did not wrap after 59");
    hour_24_a: assert property (tfh_ff && hourIf.tick && hourIf.value == `TIC_HOUR24_MAX
        && !tcenFall |=> hourIf.value == `TIC_BYTE_ZERO)
        else $error("hours did not wrap after 23");
    hour_255_a: assert property (!tfh_ff && hourIf.tick && hourIf.value == `TIC_HOUR24_MAX
        && !tcenFall |=> hourIf.value == $past(hourIf.value) + `TIC_BYTE_ONE)
        else $error("hours wrapped early in 255 mode");
    time_clear_a: assert property (tcenFall |=> fracIf.value == `TIC_BYTE_ZERO
        && secIf.value == `TIC_BYTE_ZERO && hourIf.value == `TIC_BYTE_ZERO && !time_clock_enable_ff)
        else $error("time not cleared when clock enable dropped");
    tick_gate_a: assert property (tick128 |-> time_clock_enable_ff ##1 !tick128 [*8])
        else $error("fraction tick while disabled or longer than a cycle");
    flag_set_a: assert property (intMatch |=> flag_ff && intervalFlag)
        else $error("match did not set the interval flag");
    one_shot_a: assert property (oneShotHitS |=> !interval_enable_ff ##1 intCnt_ff == `TIC_BYTE_ZERO)
        else $error("one-shot timeout left interval enabled");
    reload_a: assert property (intMatch && !oneShot_ff && !wrCtrl
        |=> interval_enable_ff && intCnt_ff == `TIC_BYTE_ZERO)
        else $error("interval counter did not reload");
    sec_base_a: assert property (interval_enable_ff && baseSel_ff == TIC_BASE_SEC && fracIf.wrap
        && !intMatch |=> intCnt_ff == $past(intCnt_ff) + `TIC_BYTE_ONE)
        else $error("seconds base did not step interval counter");
    cmp_write_a: assert property (wrCmp |=> cmp_ff == $past(sfrWrData))
        else $error("compare register write lost");
    interval_enable_off_a: assert property (!interval_enable_ff |=> intCnt_ff == `TIC_BYTE_ZERO)
        else $error("interval counter not cleared while disabled");
endmodule // tic_time_interval_regs

// File: verification/testbench.sv
// Self-checking bench for the time interval counter registers
`timescale 1ns/1ps
`include "tic_consts.svh"
module testbench;
    import tic_pkg::*;
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic timeBasePin = 1'b0;
    tic_byte_t sfrAddr = 8'h00;
    tic_byte_t sfrWrData = 8'h00;
    logic sfrWe = 1'b0;
    logic sfrRe = 1'b0;
    logic irqEnable = 1'b1;
    tic_byte_t sfrRdData;
    logic intervalFlag;
    logic intervalIrq;
    int failCount = 0;
    int nTests = 0;
    int cycles = 0;

    always #4 mclk = ~mclk;

    tic_time_interval_regs tic_time_interval_regs_inst (
        .mclk(mclk),
        .arst_n(arst_n),
        .timeBasePin(timeBasePin),
        .sfrAddr(sfrAddr),
        .sfrWrData(sfrWrData),
        .sfrWe(sfrWe),
        .sfrRe(sfrRe),
        .sfrRdData(sfrRdData),
        .irqEnable(irqEnable),
        .intervalFlag(intervalFlag),
        .intervalIrq(intervalIrq)
    );

    task automatic results();
        $display("checks %0d mismatches %0d", nTests, failCount);
        if (failCount == 0 && nTests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Cut a hang short; the whole run needs about 15600 cycles
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            failCount++;
            results();
        end
    end

    task automatic chk8(input string name, input tic_byte_t exp, input tic_byte_t got);
        nTests++;
        if (got !== exp)
        begin
            failCount++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic chk1(input string name, input logic exp, input logic got);
        nTests++;
        if (got !== exp)
        begin
            failCount++;
            $display("mismatch %s expected %b seen %b", name, exp, got);
        end
    endtask

    task automatic wr(input tic_byte_t a, input tic_byte_t d);
        @(posedge mclk);
        sfrAddr <= a;
        sfrWrData <= d;
        sfrWe <= 1'b1;
        @(posedge mclk);
        sfrWe <= 1'b0;
        #1;
    endtask

    task automatic rdChk(input string name, input tic_byte_t a, input tic_byte_t exp);
        @(posedge mclk);
        sfrAddr <= a;
        sfrRe <= 1'b1;
        @(posedge mclk);
        sfrRe <= 1'b0;
        #1;
        chk8(name, exp, sfrRdData);
    endtask

    // Rising edges of the time base, each phase held for two clock cycles
    task automatic edges(input int n);
        repeat (n)
        begin
            @(posedge mclk);
            timeBasePin <= 1'b1;
            repeat (2) @(posedge mclk);
            timeBasePin <= 1'b0;
            @(posedge mclk);
        end
        repeat (4) @(posedge mclk);
        #1;
    endtask

    // Preload fraction, seconds and minutes one tick short of their carry, hours with hourIn, then run one tick
    task automatic chain(input tic_byte_t mode, input tic_byte_t hourIn, input tic_byte_t hourExp);
        wr(`TIC_ADDR_CTRL, 8'h00);
        rdChk("hour cleared", `TIC_ADDR_HOUR, 8'h00);
        wr(`TIC_ADDR_FRAC, 8'h7F);
        wr(`TIC_ADDR_SEC, 8'h3B);
        wr(`TIC_ADDR_MIN, 8'h3B);
        wr(`TIC_ADDR_HOUR, hourIn);
        rdChk("sec written", `TIC_ADDR_SEC, 8'h3B);
        wr(`TIC_ADDR_CTRL, mode);
        wr(`TIC_ADDR_SEC, 8'h05);
        edges(256);
        rdChk("frac wrap", `TIC_ADDR_FRAC, 8'h00);
        rdChk("sec wrap", `TIC_ADDR_SEC, 8'h00);
        rdChk("min wrap", `TIC_ADDR_MIN, 8'h00);
        rdChk("hour step", `TIC_ADDR_HOUR, hourExp);
        $display("test chain mode %h hour %h done", mode, hourIn);
    endtask

    // Preload fraction, seconds and minutes, then run one tick with compare 1 on the chosen base
    task automatic baseRun(input tic_byte_t ctrl, input tic_byte_t secIn, input tic_byte_t minIn,
                           input logic flagExp, input string name);
        wr(`TIC_ADDR_CTRL, 8'h00);
        wr(`TIC_ADDR_FRAC, 8'h7F);
        wr(`TIC_ADDR_SEC, secIn);
        wr(`TIC_ADDR_MIN, minIn);
        wr(`TIC_ADDR_CMP, 8'h01);
        wr(`TIC_ADDR_CTRL, ctrl);
        edges(256);
        chk1(name, flagExp, intervalFlag);
    endtask

    initial
    begin
        repeat (4) @(posedge mclk);
        arst_n <= 1'b1;
        @(posedge mclk);
        rdChk("ctrl reset", `TIC_ADDR_CTRL, 8'h00);
        rdChk("frac reset", `TIC_ADDR_FRAC, 8'h00);
        rdChk("sec reset", `TIC_ADDR_SEC, 8'h00);
        rdChk("min reset", `TIC_ADDR_MIN, 8'h00);
        rdChk("hour reset", `TIC_ADDR_HOUR, 8'h00);
        rdChk("cmp reset", `TIC_ADDR_CMP, 8'h00);
        rdChk("unmapped", 8'hA7, 8'h00);
        chk1("flag reset", 1'b0, intervalFlag);
        $display("test reset done");
        wr(`TIC_ADDR_CMP, 8'hFF);
        rdChk("cmp max", `TIC_ADDR_CMP, 8'hFF);
        wr(`TIC_ADDR_CMP, 8'h5A);
        rdChk("cmp mid", `TIC_ADDR_CMP, 8'h5A);
        $display("test compare done");
        chain(8'h41, 8'h17, 8'h00);
        chain(8'h01, 8'h17, 8'h18);
        chain(8'h01, 8'hFF, 8'h00);
        wr(`TIC_ADDR_CTRL, 8'h00);
        wr(`TIC_ADDR_CMP, 8'h02);
        wr(`TIC_ADDR_CTRL, 8'h03);
        edges(256);
        chk1("flag early", 1'b0, intervalFlag);
        edges(256);
        chk1("flag match", 1'b1, intervalFlag);
        chk1("irq on", 1'b1, intervalIrq);
        @(posedge mclk);
        irqEnable <= 1'b0;
        @(posedge mclk);
        #1;
        chk1("irq masked", 1'b0, intervalIrq);
        irqEnable <= 1'b1;
        rdChk("ctrl reload", `TIC_ADDR_CTRL, 8'h07);
        wr(`TIC_ADDR_CTRL, 8'h03);
        chk1("flag cleared", 1'b0, intervalFlag);
        edges(512);
        chk1("flag again", 1'b1, intervalFlag);
        $display("test interval reload done");
        wr(`TIC_ADDR_CMP, 8'h01);
        wr(`TIC_ADDR_CTRL, 8'h0B);
        edges(256);
        rdChk("ctrl oneshot", `TIC_ADDR_CTRL, 8'h0D);
        wr(`TIC_ADDR_CTRL, 8'h09);
        edges(256);
        chk1("flag stopped", 1'b0, intervalFlag);
        $display("test interval oneshot done");
        wr(`TIC_ADDR_CTRL, 8'h00);
        wr(`TIC_ADDR_FRAC, 8'h7E);
        wr(`TIC_ADDR_CTRL, 8'h13);
        edges(256);
        chk1("sec base early", 1'b0, intervalFlag);
        edges(256);
        chk1("sec base match", 1'b1, intervalFlag);
        baseRun(8'h23, 8'h3A, 8'h00, 1'b0, "min base early");
        baseRun(8'h23, 8'h3B, 8'h00, 1'b1, "min base match");
        baseRun(8'h33, 8'h3B, 8'h3A, 1'b0, "hour base early");
        baseRun(8'h33, 8'h3B, 8'h3B, 1'b1, "hour base match");
        $display("test interval base done");
        results();
    end
endmodule // testbench
